// file: design/task_sync_pkg.sv
// What this block does
// (R01) Producer emits one trigger per position-task period, 250 us to 8 ms.
// (R02) Consumer re-phases its task schedule start on each received trigger.
// (R03) Consumer synchronises when its period is equal to or shorter.
// (R04) Consumer with a longer period ignores triggers and reports not-achieved.
// (R05) Role value 1 is producer, 2 is consumer; one producer only.
// (R06) Status 5 producer, 6 consumer, 13 producer via cross-drive interrupt.
// (R07) Status 2 when a consumer's position task is too slow.
// (R08) Status is read-only and shows whether the requested role is achieved.
// (R09) Cross-drive sync slave forces the effective role to producer.
// (R10) Period codes: 1=250 us, 2=500 us, 3=1 ms, 4=2 ms.
// (R11) Cross-drive mode: 1 not participating (default), 25 master, 26 slave.
// (R12) Each period runs first task, advanced controller, second task in order.
// (R13) Only the start of the whole task group is aligned.
// (R14) Trigger travels between modules inside the drive, no external wiring.
// (R15) Consumer restarts its period counter at every received trigger it synchronises to.
package task_sync_pkg;

    // ========================================================
    // Register map
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam int ROLE_LSB   = 0;
    localparam int PERIOD_LSB = 8;
    localparam int XMODE_LSB  = 16;

    // ========================================================
    // Codes and reset values
    localparam logic [7:0] ROLE_NONE      = 8'h00;
    localparam logic [7:0] ROLE_PRODUCER  = 8'h01;
    localparam logic [7:0] ROLE_CONSUMER  = 8'h02;
    localparam logic [7:0] PERIOD_RESET   = 8'h01;
    localparam logic [7:0] XMODE_OFF      = 8'h01;
    localparam logic [7:0] XMODE_MASTER   = 8'h19;
    localparam logic [7:0] XMODE_SLAVE    = 8'h1A;
    localparam logic [7:0] STAT_IDLE      = 8'h00;
    localparam logic [7:0] STAT_TOO_SLOW  = 8'h02;
    localparam logic [7:0] STAT_PROD_OK   = 8'h05;
    localparam logic [7:0] STAT_CONS_OK   = 8'h06;
    localparam logic [7:0] STAT_PROD_XD   = 8'h0D;

    // ========================================================
    // Timing: one base tick is the shortest task period
    localparam int CLK_NS      = 40;
    localparam int TICK_NS     = 250000;
    localparam int TICK_CYCLES = TICK_NS / CLK_NS;

    // Task strobes travel together
    typedef struct packed {
        logic first_task;
        logic apc_task;
        logic second_task;
    } task_strobes_t;

endpackage

// file: design/task_sync.sv
`timescale 1ns/1ps
module task_sync #(
    parameter int TICK_CYCLES_P = task_sync_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                       clock_i,
    input  wire logic                       rst_i,
    // APB slave
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire logic [7:0]                 paddr_i,
    input  wire logic [31:0]                pwdata_i,
    output logic      [31:0]                prdata_o,
    output logic                            pready_o,
    output logic                            pslverr_o,
    // In-drive trigger bus and cross-drive event
    input  wire logic                       sync_trigger_i,
    input  wire logic [7:0]                 producer_period_i,
    input  wire logic                       cross_drive_interrupt_i,
    output logic                            sync_trigger_o,
    // Position task starts
    output task_sync_pkg::task_strobes_t    task_strobes_o
);
    import task_sync_pkg::*;

    // ========================================================
    // Decoding
    // Period code to base ticks; 5 and 6 extend to 4 ms and 8 ms
    // Unknown codes fall back to the shortest period, never to zero
    function automatic logic [5:0] period_ticks(input logic [7:0] code);
        case (code)
            8'h01:   period_ticks = 6'h01; // [R10]
            8'h02:   period_ticks = 6'h02; // [R10]
            8'h03:   period_ticks = 6'h04; // [R10]
            8'h04:   period_ticks = 6'h08; // [R10]
            8'h05:   period_ticks = 6'h10;
            8'h06:   period_ticks = 6'h20; // [R01]
            default: period_ticks = 6'h01;
        endcase
    endfunction

    logic [7:0]    role_r;
    logic [7:0]    period_r;
    logic [7:0]    xmode_r;
    logic [7:0]    status_r;
    logic [31:0]   prdata_r;
    logic          pready_r;
    logic          pslverr_r;
    logic [17:0]   tick_cnt_r;
    logic [5:0]    slot_cnt_r;
    logic          cons_lock_r;
    logic          xd_lock_r;
    logic          trig_r;
    task_strobes_t strobes_r;

    logic          xslave;
    logic [7:0]    eff_role;
    logic          is_prod;
    logic          is_cons;
    logic [5:0]    own_ticks;
    logic          can_sync;
    logic          tick_en;
    logic          period_end;
    logic          resync;
    logic          phase_evt;
    logic          wr_en;
    logic          ctrl_wr;

    // ========================================================
    // Role and phase decisions
    // Cross-drive slave overrides the software role
    assign xslave    = (xmode_r == XMODE_SLAVE);
    assign eff_role  = xslave ? ROLE_PRODUCER : role_r; // [R09]
    assign is_prod   = (eff_role == ROLE_PRODUCER); // [R05]
    assign is_cons   = (eff_role == ROLE_CONSUMER); // [R05]
    assign own_ticks = period_ticks(period_r);
    // Only a period no longer than the producer's can know its phase
    assign can_sync  = own_ticks <= period_ticks(producer_period_i); // [R03]
    assign tick_en   = (tick_cnt_r == 18'(TICK_CYCLES_P - 1));
    assign period_end = tick_en && (slot_cnt_r == own_ticks - 6'h01);
    // Consumer follows trigger; slave producer follows cross-drive event
    assign resync = (is_cons && can_sync && sync_trigger_i) // [R02] [R04]
                  || (is_prod && xslave && cross_drive_interrupt_i);
    assign phase_evt = period_end || resync;
    assign wr_en   = psel_i && penable_i && pready_r && pwrite_i;
    assign ctrl_wr = wr_en && (paddr_i == CTRL_ADDR);

    // ========================================================
    // Base tick divider, restarted on every phase event
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt_r <= 18'h00000;
        end else if (phase_evt || tick_en) begin
            tick_cnt_r <= 18'h00000; // [R15]
        end else begin
            tick_cnt_r <= tick_cnt_r + 18'h00001;
        end
    end

    // Ticks within the current task period
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            slot_cnt_r <= 6'h00;
        end else if (phase_evt) begin
            slot_cnt_r <= 6'h00; // [R15]
        end else if (tick_en) begin
            slot_cnt_r <= slot_cnt_r + 6'h01;
        end
    end

    // ========================================================
    // Task group sequencing: only the group start is aligned
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            strobes_r <= '0;
        end else begin
            strobes_r.first_task  <= phase_evt; // [R13]
            strobes_r.apc_task    <= strobes_r.first_task; // [R12]
            strobes_r.second_task <= strobes_r.apc_task; // [R12]
        end
    end

    // Producer drives the in-drive trigger once per period
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            trig_r <= 1'b0;
        end else begin
            trig_r <= phase_evt && is_prod; // [R01] [R14]
        end
    end

    // ========================================================
    // Lock flags; a reconfiguration drops them, an event wins
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cons_lock_r <= 1'b0;
        end else if (resync && is_cons) begin
            cons_lock_r <= 1'b1;
        end else if (ctrl_wr || !is_cons || !can_sync) begin
            cons_lock_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            xd_lock_r <= 1'b0;
        end else if (resync && is_prod) begin
            xd_lock_r <= 1'b1;
        end else if (ctrl_wr || !xslave) begin
            xd_lock_r <= 1'b0;
        end
    end

    // Status code, hardware owned
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            status_r <= STAT_IDLE;
        end else if (is_prod) begin
            status_r <= (xslave && xd_lock_r) ? STAT_PROD_XD // [R06]
                                              : STAT_PROD_OK; // [R06]
        end else if (is_cons && !can_sync) begin
            status_r <= STAT_TOO_SLOW; // [R07] [R04]
        end else if (is_cons && cons_lock_r) begin
            status_r <= STAT_CONS_OK; // [R06]
        end else begin
            status_r <= STAT_IDLE;
        end
    end

    // ========================================================
    // APB: one wait state, then pready with data or error
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else begin
            pready_r  <= psel_i && penable_i && !pready_r;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
            if (psel_i && penable_i && !pready_r) begin
                case (paddr_i)
                    CTRL_ADDR: begin
                        prdata_r <= {8'h00, xmode_r, period_r, role_r};
                    end
                    STATUS_ADDR: begin
                        prdata_r <= {16'h0000, eff_role, status_r}; // [R08]
                    end
                    default: begin
                        pslverr_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Control register; status writes are dropped silently
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            role_r   <= ROLE_NONE;
            period_r <= PERIOD_RESET;
            xmode_r  <= XMODE_OFF; // [R11]
        end else if (ctrl_wr) begin
            role_r   <= pwdata_i[ROLE_LSB +: 8]; // [R05]
            period_r <= pwdata_i[PERIOD_LSB +: 8]; // [R10]
            xmode_r  <= pwdata_i[XMODE_LSB +: 8]; // [R11]
        end
    end

    assign prdata_o       = prdata_r;
    assign pready_o       = pready_r;
    assign pslverr_o      = pslverr_r;
    assign sync_trigger_o = trig_r;
    assign task_strobes_o = strobes_r;

    // ========================================================
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    task_order_a: assert property ( // [R12]
        strobes_r.first_task |=> strobes_r.apc_task ##1 strobes_r.second_task)
        else $error("task order broken");

    trig_per_period_a: assert property ( // [R01]
        (is_prod && period_end) |=> trig_r)
        else $error("producer missed trigger");

    cons_no_trig_a: assert property ( // [R05]
        (!is_prod) |=> !trig_r)
        else $error("non-producer drove trigger");

    cons_rephase_a: assert property ( // [R02]
        (is_cons && can_sync && sync_trigger_i) |=> strobes_r.first_task
            && slot_cnt_r == 6'h00 && tick_cnt_r == 18'h00000)
        else $error("consumer did not rephase");

    slow_ignore_a: assert property ( // [R04]
        (is_cons && !can_sync && sync_trigger_i && !period_end)
            |=> !strobes_r.first_task)
        else $error("slow consumer followed trigger");

    slow_status_a: assert property ( // [R07]
        (is_cons && !can_sync) |=> status_r == STAT_TOO_SLOW)
        else $error("slow status wrong");

    xslave_role_a: assert property ( // [R09]
        xslave |=> (status_r == STAT_PROD_OK || status_r == STAT_PROD_XD))
        else $error("slave not forced producer");

    prod_status_a: assert property ( // [R06]
        (is_prod && !xslave) |=> status_r == STAT_PROD_OK)
        else $error("producer status wrong");

    cons_ok_a: assert property ( // [R06]
        (is_cons && can_sync && sync_trigger_i) ##1 is_cons && can_sync
            && !ctrl_wr |=> status_r == STAT_CONS_OK)
        else $error("consumer status wrong");

    status_ro_a: assert property ( // [R08]
        (wr_en && paddr_i == STATUS_ADDR) |=> $stable(role_r))
        else $error("status write changed control");

    apb_wait_a: assert property (
        (psel_i && penable_i && !pready_r) |=> pready_r ##1 !pready_r)
        else $error("apb timing wrong");

    // Cross-drive event re-phases a forced producer and shows in status
    xd_phase_a: assert property ( // [R09]
        (is_prod && xslave && cross_drive_interrupt_i)
            |=> trig_r && strobes_r.first_task)
        else $error("slave producer ignored event");

    xd_status_a: assert property ( // [R06]
        (xslave && xd_lock_r) |=> status_r == STAT_PROD_XD)
        else $error("cross-drive status wrong");

    // No role requested means nothing to achieve
    idle_status_a: assert property ( // [R08]
        (!is_prod && !is_cons) |=> status_r == STAT_IDLE)
        else $error("idle status wrong");

    slow_lock_a: assert property ( // [R04]
        (is_cons && !can_sync) |=> !cons_lock_r)
        else $error("slow consumer kept lock");

    group_start_a: assert property ( // [R13]
        phase_evt |=> strobes_r.first_task)
        else $error("group start missed");

    // Unmapped offsets answer on time, flagged, so a master never hangs
    apb_err_a: assert property (
        (psel_i && penable_i && !pready_r && paddr_i != CTRL_ADDR
            && paddr_i != STATUS_ADDR) |=> pready_r && pslverr_r)
        else $error("unmapped access not refused");

    cons_sync_c: cover property (is_cons && resync ##1 status_r == 8'h00);
    prod_xd_c: cover property (status_r == STAT_PROD_XD);
    slow_c: cover property (status_r == STAT_TOO_SLOW);
    group_c: cover property (trig_r ##2 strobes_r.second_task);
    cons_ok_c: cover property (status_r == STAT_CONS_OK);

endmodule

// file: verif/producer_model.sv
`timescale 1ns/1ps
// ==========================================================
// Peer option module acting as the single in-drive producer
module producer_model #(
    parameter int TICK_P = 10
) (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    // Bench control
    input  wire logic       en_i,
    input  wire logic [7:0] code_i,
    // Trigger bus toward the block
    output logic            trig_o,
    output logic [7:0]      period_o
);
    int cnt_r;

    // Period code is a level, held for the whole run
    assign period_o = code_i;

    // One pulse per own period; only one producer on the bus
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r  <= 0;
            trig_o <= 1'b0;
        end else if (!en_i) begin
            cnt_r  <= 0;
            trig_o <= 1'b0;
        end else if (cnt_r >= (TICK_P << (code_i - 1)) - 1) begin
            cnt_r  <= 0;
            trig_o <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 1;
            trig_o <= 1'b0;
        end
    end
endmodule

// file: verif/test_task_sync.sv
`timescale 1ns/1ps
module test_task_sync;
    import task_sync_pkg::*;
    localparam int TK = 10;
    typedef struct packed {
        logic        err;
        logic        rd;
        logic [31:0] d;
    } exp_t;
    logic          clock_i = 1'b0;
    logic          rst_i = 1'b1;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0;
    logic [31:0]   prdata_o;
    logic          pready_o;
    logic          pslverr_o;
    logic          trig;
    logic [7:0]    pcode;
    logic [7:0]    pcode_r = 8'h02;
    logic          pen = 1'b0;
    logic          cdi = 1'b0;
    logic          sync_trigger_o;
    task_strobes_t task_strobes_o;
    exp_t          exp_q[$];
    exp_t          e;
    int            n_mismatch = 0;
    int            checked = 0;
    int            per = 0;
    int            gap = 0;
    logic          cons = 1'b0;
    logic          xs = 1'b0;
    logic          pf, pa, pt, pc;

    // ==========================================================
    // Clock, design and in-drive producer peer
    always #20 clock_i = ~clock_i;

    task_sync #(.TICK_CYCLES_P(TK)) u_task_sync (
        .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .sync_trigger_i(trig),
        .producer_period_i(pcode), .cross_drive_interrupt_i(cdi),
        .sync_trigger_o(sync_trigger_o), .task_strobes_o(task_strobes_o));

    producer_model #(.TICK_P(TK)) u_producer_model (
        .clock_i(clock_i), .rst_i(rst_i), .en_i(pen),
        .code_i(pcode_r), .trig_o(trig), .period_o(pcode));

    // ==========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] s);
        checked++;
        if (s !== x) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, x, s);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Full APB transfer; only the watchdog ends a wait on pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] x,
                       input logic er);
        exp_q.push_back({er, !w, x});
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        do begin
            @(posedge clock_i);
        end while (pready_o !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock_i);
    endtask

    // ==========================================================
    // Watcher: pops expected APB results, checks strobe timing
    always @(posedge clock_i) begin
        if (pready_o === 1'b1) begin
            e = exp_q.pop_front();
            chk("pslverr", e.err, pslverr_o);
            if (e.rd) chk("prdata", e.d, prdata_o);
        end
        if (pf) chk("apc", 1, task_strobes_o.apc_task);
        if (pa) chk("second", 1, task_strobes_o.second_task);
        if (pt && cons) chk("resync", 1, task_strobes_o.first_task);
        if (pc && xs) chk("xd_trig", 1, sync_trigger_o);
        if (sync_trigger_o === 1'b1) begin
            if (per != 0 && gap != 0) chk("period", per, gap);
            gap = 1;
        end else if (gap != 0) begin
            gap++;
        end
        pf = (task_strobes_o.first_task === 1'b1);
        pa = (task_strobes_o.apc_task === 1'b1);
        pt = (trig === 1'b1);
        pc = (cdi === 1'b1);
    end

    // Hang guard, well beyond the planned few thousand cycles
    initial begin
        #(40 * 8000);
        n_mismatch++;
        close_out();
    end

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(20));
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        apb(0, CTRL_ADDR, 0, {XMODE_OFF, PERIOD_RESET, ROLE_NONE}, 0);
        apb(1, STATUS_ADDR, $urandom(), 0, 0);
        apb(0, STATUS_ADDR, 0, 0, 0);
        apb(0, 8'h08, 0, 0, 1);
        // Producer at every period code; master mode only stored
        for (int c = 1; c <= 6; c++) begin
            per = 0;
            apb(1, CTRL_ADDR, {XMODE_MASTER, 8'(c), ROLE_PRODUCER},
                0, 0);
            gap = 0;
            per = TK << (c - 1);
            repeat (per * 3) @(posedge clock_i);
            apb(0, STATUS_ADDR, 0, {ROLE_PRODUCER, STAT_PROD_OK}, 0);
        end
        per = 0;
        // Faster consumer locks to a peer started at a random phase
        apb(1, CTRL_ADDR, {XMODE_OFF, 8'h01, ROLE_CONSUMER}, 0, 0);
        repeat ($urandom_range(15)) @(posedge clock_i);
        pen  <= 1'b1;
        cons <= 1'b1;
        repeat (70) @(posedge clock_i);
        apb(0, STATUS_ADDR, 0, {ROLE_CONSUMER, STAT_CONS_OK}, 0);
        // Slower consumer must refuse to lock
        cons <= 1'b0;
        apb(1, CTRL_ADDR, {XMODE_OFF, 8'h03, ROLE_CONSUMER}, 0, 0);
        repeat (70) @(posedge clock_i);
        apb(0, STATUS_ADDR, 0, {ROLE_CONSUMER, STAT_TOO_SLOW}, 0);
        // Cross-drive slave acts as producer, phased by the event
        pen <= 1'b0;
        apb(1, CTRL_ADDR, {XMODE_SLAVE, 8'h01, ROLE_CONSUMER}, 0, 0);
        xs <= 1'b1;
        repeat ($urandom_range(15) + 1) @(posedge clock_i);
        cdi <= 1'b1;
        @(posedge clock_i);
        cdi <= 1'b0;
        repeat (5) @(posedge clock_i);
        apb(0, STATUS_ADDR, 0, {ROLE_PRODUCER, STAT_PROD_XD}, 0);
        apb(0, CTRL_ADDR, 0, {XMODE_SLAVE, 8'h01, ROLE_CONSUMER}, 0);
        close_out();
    end
endmodule
